// file: rtl/ltf_pkg.sv
// Constants and types shared by the logical test flag unit.
// Assumes a 32-bit core with sixteen general registers and one core clock.
package ltf_pkg;

    // ==========================================================
    // Datapath sizes
    localparam int DATA_W      = 32;
    localparam int REG_CNT     = 16;
    localparam int REG_IDX_W   = 4;
    localparam int IMM_W       = 8;
    localparam int AMT_W       = 8;
    localparam int ADDR_W      = 8;

    // ==========================================================
    // Status word layout and value after reset
    localparam int FLAG_N      = 31;
    localparam int FLAG_Z      = 30;
    localparam int FLAG_C      = 29;
    localparam int FLAG_V      = 28;
    localparam int FLAG_LO     = 28;
    localparam int MODE_HI     = 1;
    localparam int MODE_LO     = 0;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] COUNT_RESET  = 32'h0000_0000;

    // ==========================================================
    // Register port map (byte addresses)
    localparam logic [7:0] STATUS_ADDR = 8'h00;
    localparam logic [7:0] COUNT_ADDR  = 8'h04;

    // ==========================================================
    // Operand shifter kinds
    typedef enum logic [2:0] {
        arith_left_shift     = 3'b000,
        logical_left_shift   = 3'b001,
        logical_right_shift  = 3'b010,
        arith_right_shift    = 3'b011,
        rotate_right         = 3'b100,
        rotate_through_carry = 3'b101
    } ltf_shift_t;

    // ==========================================================
    // Condition codes
    typedef enum logic [3:0] {
        COND_EQ = 4'h0, COND_NE = 4'h1, COND_CS = 4'h2, COND_CC = 4'h3,
        COND_MI = 4'h4, COND_PL = 4'h5, COND_VS = 4'h6, COND_VC = 4'h7,
        COND_HI = 4'h8, COND_LS = 4'h9, COND_GE = 4'hA, COND_LT = 4'hB,
        COND_GT = 4'hC, COND_LE = 4'hD, COND_AL = 4'hE, COND_NV = 4'hF
    } ltf_cond_t;

endpackage

// file: rtl/ltf_regfile.sv
// Small general register store with one write port and registered reads.
// Assumes writes come from the core's writeback stage on ref_clk.
`timescale 1ns/100ps
module ltf_regfile #(
    parameter int WIDTH    = 32,
    parameter int DEPTH    = 16,
    parameter int IDX_W    = 4,
    parameter int RD_PORTS = 3
) (
    input  wire logic                      ref_clk,
    input  wire logic                      wr_en,
    input  wire logic [IDX_W-1:0]          wr_idx,
    input  wire logic [WIDTH-1:0]          wr_data,
    input  wire logic [RD_PORTS*IDX_W-1:0] rd_idx,
    output logic      [RD_PORTS*WIDTH-1:0] rd_data
);

    // ==========================================================
    // Storage
    logic [WIDTH-1:0] mem [DEPTH];

    if (DEPTH > (1 << IDX_W) || RD_PORTS < 1) begin : g_check
        $error("ltf_regfile: depth or port count not supported");
    end

    // Write port
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    // One registered read per port
    for (genvar p = 0; p < RD_PORTS; p++) begin : g_rd
        always_ff @(posedge ref_clk) begin
            rd_data[p*WIDTH +: WIDTH] <= mem[rd_idx[p*IDX_W +: IDX_W]];
        end
    end

endmodule

// file: rtl/ltf_shifter.sv
// Combinational operand shifter with carry out.
// Assumes the amount is already chosen: constant, register byte or immediate rotate.
`timescale 1ns/100ps
module ltf_shifter (
    input  wire logic [31:0]           value_in,
    input  wire ltf_pkg::ltf_shift_t   kind,
    input  wire logic [7:0]            amount,
    input  wire logic                  carry_in,
    output logic      [31:0]           value_out,
    output logic                       carry_out
);

    // ==========================================================
    // Shift paths
    logic [32:0] left_w;
    logic [32:0] right_w;
    logic [32:0] asr_w;
    logic [63:0] rot_w;
    logic [7:0]  asr_amt;

    // Left: carry lands in bit 32; right: carry lands in bit 0
    assign left_w  = {1'b0, value_in} << amount;
    assign right_w = {value_in, 1'b0} >> amount;
    assign asr_amt = (amount > 8'h20) ? 8'h20 : amount;
    assign asr_w   = 33'($signed({value_in, 1'b0}) >>> asr_amt);
    assign rot_w   = {value_in, value_in} >> amount[4:0];

    // Select by kind; a zero count passes the value and carry through, except for the carry rotate, which ignores the count
    always_comb begin
        value_out = value_in;
        carry_out = carry_in;
        if (kind == ltf_pkg::rotate_through_carry) begin
            value_out = {carry_in, value_in[31:1]}; // RULE12
            carry_out = value_in[0];
        end else if (amount != 8'h00) begin
            unique case (kind)
                ltf_pkg::arith_left_shift, ltf_pkg::logical_left_shift: begin
                    value_out = left_w[31:0]; // RULE12
                    carry_out = left_w[32];
                end
                ltf_pkg::logical_right_shift: begin
                    value_out = right_w[32:1]; // RULE12
                    carry_out = right_w[0];
                end
                ltf_pkg::arith_right_shift: begin
                    value_out = asr_w[32:1]; // RULE12
                    carry_out = asr_w[0];
                end
                ltf_pkg::rotate_right: begin
                    value_out = rot_w[31:0]; // RULE12
                    carry_out = rot_w[31];
                end
                default: begin
                    value_out = value_in;
                    carry_out = carry_in;
                end
            endcase
        end
    end

endmodule

// file: rtl/ltf_unit.sv
// Logical test flag unit: equality (XOR) and mask (AND) tests on flags only.
// Assumes decode presents one instruction per issue pulse and writeback
// feeds the register store; no forwarding from a write in the same cycle.
//
// What this block does
// RULE1: equality test XORs, discards result
// RULE2: equality test clears carry, keeps overflow
// RULE3: only N, Z, C flags change
// RULE4: mask test ANDs, stores no result
// RULE5: mask test keeps overflow unchanged
// RULE6: flags update regardless of save bit
// RULE7: equality status-load copies bits 31:28, 1:0
// RULE8: mask status-load copies bits 31:28
// RULE9: immediate is 8 bits rotated in field
// RULE10: register shift counts 0 to 255
// RULE11: constant shift counts 0 to 31
// RULE12: shifter offers all kinds plus carry rotate
// RULE13: any of sixteen registers is first operand
// RULE14: condition code gates execution
// RULE15: N from bit 31, Z when all zero
`timescale 1ns/100ps
module ltf_unit #(
    parameter int DATA_W = 32,
    parameter int REG_CNT = 16
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    // Instruction issue from decode
    input  wire logic                      issue_valid,
    input  wire logic                      issue_is_mask,
    input  wire logic [3:0]                issue_cond,
    input  wire logic                      issue_status_load,
    input  wire logic [3:0]                first_operand_register,
    input  wire logic                      op2_is_imm,
    input  wire logic [7:0]                imm_value,
    input  wire logic [3:0]                imm_rotate,
    input  wire logic [3:0]                shifted_operand_register,
    input  wire logic [3:0]                shift_amount_register,
    input  wire logic                      shift_by_register,
    input  wire logic [2:0]                shift_kind,
    input  wire logic [4:0]                shift_const,
    // Writeback into the register store
    input  wire logic                      wb_en,
    input  wire logic [3:0]                wb_idx,
    input  wire logic [31:0]               wb_data,
    // Software register port
    input  wire logic [7:0]                reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [31:0]               reg_rdata,
    // Results
    output logic      [31:0]               processor_status_word,
    output logic      [31:0]               alu_result,
    output logic                           flags_update,
    output logic                           test_skipped
);

    // ==========================================================
    // Elaboration check
    if (DATA_W != ltf_pkg::DATA_W || REG_CNT != ltf_pkg::REG_CNT) begin : g_check
        $error("ltf_unit: only a 32-bit datapath with sixteen registers is supported");
    end

    // ==========================================================
    // Issue stage: latch decode fields while the store reads
    logic        valid_r;
    logic        is_mask_r;
    logic [3:0]  cond_r;
    logic        status_load_r;
    logic        imm_sel_r;
    logic [7:0]  imm_value_r;
    logic [3:0]  imm_rotate_r;
    logic        by_reg_r;
    logic [2:0]  kind_r;
    logic [4:0]  const_r;

    // Valid bit has a defined reset value
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            valid_r <= 1'b0;
        end else begin
            valid_r <= issue_valid;
        end
    end

    // Decode fields ride alongside the read
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            is_mask_r     <= 1'b0;
            cond_r        <= 4'h0;
            status_load_r <= 1'b0;
            imm_sel_r     <= 1'b0;
            imm_value_r   <= 8'h00;
            imm_rotate_r  <= 4'h0;
            by_reg_r      <= 1'b0;
            kind_r        <= 3'h0;
            const_r       <= 5'h00;
        end else if (issue_valid) begin
            is_mask_r     <= issue_is_mask;
            cond_r        <= issue_cond;
            status_load_r <= issue_status_load;
            imm_sel_r     <= op2_is_imm;
            imm_value_r   <= imm_value;
            imm_rotate_r  <= imm_rotate;
            by_reg_r      <= shift_by_register;
            kind_r        <= shift_kind;
            const_r       <= shift_const;
        end
    end

    // ==========================================================
    // Register store: three read ports for first, shifted and amount
    logic [11:0] rd_idx;
    logic [95:0] rd_data;
    logic [31:0] first_val;
    logic [31:0] shifted_val;
    logic [31:0] amount_val;

    // Any of the sixteen registers may be named as first operand
    assign rd_idx = {shift_amount_register, shifted_operand_register, first_operand_register}; // RULE13

    ltf_regfile #(
        .WIDTH    (32),
        .DEPTH    (16),
        .IDX_W    (4),
        .RD_PORTS (3)
    ) u_regs (
        .ref_clk (ref_clk),
        .wr_en   (wb_en),
        .wr_idx  (wb_idx),
        .wr_data (wb_data),
        .rd_idx  (rd_idx),
        .rd_data (rd_data)
    );

    assign first_val   = rd_data[31:0];
    assign shifted_val = rd_data[63:32];
    assign amount_val  = rd_data[95:64];

    // ==========================================================
    // Second operand selection
    logic [31:0]        sh_in;
    ltf_pkg::ltf_shift_t sh_kind;
    logic [7:0]         sh_amt;
    logic [31:0]        second_operand;
    logic               sh_carry;
    logic [31:0]        status_r;

    // Immediate rotates right by twice the field; else register shift
    always_comb begin
        sh_in   = shifted_val;
        sh_kind = ltf_pkg::ltf_shift_t'(kind_r);
        sh_amt  = {3'b000, const_r}; // RULE11
        if (imm_sel_r) begin
            sh_in   = {24'h00_0000, imm_value_r}; // RULE9
            sh_kind = ltf_pkg::rotate_right;
            sh_amt  = {3'b000, imm_rotate_r, 1'b0}; // RULE9
        end else if (kind_r == ltf_pkg::rotate_through_carry) begin
            sh_amt = 8'h01;
        end else if (by_reg_r) begin
            sh_amt = amount_val[7:0]; // RULE10
        end
    end

    ltf_shifter u_shift (
        .value_in  (sh_in),
        .kind      (sh_kind),
        .amount    (sh_amt),
        .carry_in  (status_r[ltf_pkg::FLAG_C]),
        .value_out (second_operand),
        .carry_out (sh_carry)
    );

    // ==========================================================
    // Logic result and computed flags
    logic [31:0] logic_res;
    logic        res_neg;
    logic        res_zero;
    logic        res_carry;

    // XOR for the equality test, AND for the mask test
    always_comb begin
        if (is_mask_r) begin
            logic_res = first_val & second_operand; // RULE4
        end else begin
            logic_res = first_val ^ second_operand; // RULE1
        end
    end

    assign res_neg   = logic_res[31]; // RULE15
    assign res_zero  = (logic_res == 32'h0000_0000); // RULE15
    // Equality forces carry low; mask takes the shifter carry
    assign res_carry = is_mask_r ? sh_carry : 1'b0; // RULE2

    // ==========================================================
    // Condition evaluation against the current flags
    function automatic logic cond_pass(input logic [3:0] cc, input logic [31:0] sw);
        logic n;
        logic z;
        logic c;
        logic v;
        logic pass;
        n = sw[ltf_pkg::FLAG_N];
        z = sw[ltf_pkg::FLAG_Z];
        c = sw[ltf_pkg::FLAG_C];
        v = sw[ltf_pkg::FLAG_V];
        unique case (ltf_pkg::ltf_cond_t'(cc))
            ltf_pkg::COND_EQ: pass = z;
            ltf_pkg::COND_NE: pass = !z;
            ltf_pkg::COND_CS: pass = c;
            ltf_pkg::COND_CC: pass = !c;
            ltf_pkg::COND_MI: pass = n;
            ltf_pkg::COND_PL: pass = !n;
            ltf_pkg::COND_VS: pass = v;
            ltf_pkg::COND_VC: pass = !v;
            ltf_pkg::COND_HI: pass = c && !z;
            ltf_pkg::COND_LS: pass = !c || z;
            ltf_pkg::COND_GE: pass = (n == v);
            ltf_pkg::COND_LT: pass = (n != v);
            ltf_pkg::COND_GT: pass = !z && (n == v);
            ltf_pkg::COND_LE: pass = z || (n != v);
            ltf_pkg::COND_AL: pass = 1'b1;
            ltf_pkg::COND_NV: pass = 1'b0;
        endcase
        return pass;
    endfunction

    logic exec_now;
    logic skip_now;

    // Only instructions whose condition holds touch the flags
    assign exec_now = valid_r && cond_pass(cond_r, status_r); // RULE14
    assign skip_now = valid_r && !exec_now;

    // ==========================================================
    // Status word update
    logic [31:0] status_base;
    logic [31:0] status_nxt;
    logic        sw_status_wr;

    assign sw_status_wr = reg_wr && (reg_addr == ltf_pkg::STATUS_ADDR);
    assign status_base  = sw_status_wr ? reg_wdata : status_r;

    // Flag update wins over a software write in the same cycle
    always_comb begin
        status_nxt = status_base;
        if (exec_now) begin
            if (status_load_r) begin
                status_nxt[31:ltf_pkg::FLAG_LO] = logic_res[31:ltf_pkg::FLAG_LO]; // RULE8
                if (!is_mask_r) begin
                    status_nxt[ltf_pkg::MODE_HI:ltf_pkg::MODE_LO] =
                        logic_res[ltf_pkg::MODE_HI:ltf_pkg::MODE_LO]; // RULE7
                end
            end else begin
                // Updated with no save bit needed; V and all else kept
                status_nxt[ltf_pkg::FLAG_N] = res_neg; // RULE6
                status_nxt[ltf_pkg::FLAG_Z] = res_zero; // RULE3
                status_nxt[ltf_pkg::FLAG_C] = res_carry; // RULE3
                status_nxt[ltf_pkg::FLAG_V] = status_base[ltf_pkg::FLAG_V]; // RULE5
            end
        end
    end

    // Status word register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_r <= ltf_pkg::STATUS_RESET;
        end else begin
            status_r <= status_nxt;
        end
    end

    // ==========================================================
    // Observation: last result, pulses and executed count
    logic [31:0] result_r;
    logic        update_r;
    logic        skipped_r;
    logic [31:0] count_r;

    // Result is held for observation only, never written to a register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            result_r <= 32'h0000_0000;
        end else if (exec_now) begin
            result_r <= logic_res; // RULE1
        end
    end

    // One-cycle pulses aligned with the new status word
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            update_r  <= 1'b0;
            skipped_r <= 1'b0;
        end else begin
            update_r  <= exec_now;
            skipped_r <= skip_now;
        end
    end

    // Executed count; an execution in the write cycle still counts
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_r <= ltf_pkg::COUNT_RESET;
        end else if (reg_wr && reg_addr == ltf_pkg::COUNT_ADDR) begin
            count_r <= reg_wdata + {31'h0000_0000, exec_now};
        end else if (exec_now) begin
            count_r <= count_r + 32'h0000_0001;
        end
    end

    // ==========================================================
    // Register read port, data one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ltf_pkg::STATUS_ADDR: reg_rdata <= status_r;
                ltf_pkg::COUNT_ADDR:  reg_rdata <= count_r;
                default:              reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    assign processor_status_word = status_r;
    assign alu_result            = result_r;
    assign flags_update          = update_r;
    assign test_skipped          = skipped_r;

endmodule

// file: tb/ltf_monitor.sv
// Port checks for the logical test flag unit.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module ltf_monitor (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        issue_valid,
    input wire logic        issue_is_mask,
    input wire logic        issue_status_load,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [31:0] processor_status_word,
    input wire logic [31:0] alu_result,
    input wire logic        flags_update,
    input wire logic        test_skipped
);
    // ==========================================================
    // Clock and reset
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // ==========================================================
    // Issue timing and pulses
    chk_pulse_excl: assert property (!(flags_update && test_skipped))
        else $error("update and skip both");
    chk_issue_answer: assert property (issue_valid |-> ##2 (flags_update ^ test_skipped))
        else $error("no answer to issue");
    chk_update_cause: assert property (flags_update |-> $past(issue_valid, 2))
        else $error("update without issue");

    // ==========================================================
    // Flag values after a test
    chk_low_kept: assert property (flags_update && !$past(issue_status_load, 2) && !$past(reg_wr)
        |-> processor_status_word[28:0] == $past(processor_status_word[28:0]))
        else $error("other status bits changed");
    chk_eq_carry: assert property (flags_update && !$past(issue_is_mask, 2) && !$past(issue_status_load, 2)
        |-> !processor_status_word[29])
        else $error("equality carry set");
    chk_nz_flags: assert property (flags_update && !$past(issue_status_load, 2)
        |-> processor_status_word[31] == alu_result[31]
            && processor_status_word[30] == (alu_result == 32'h0000_0000))
        else $error("N or Z wrong");
    chk_load_high: assert property (flags_update && $past(issue_status_load, 2)
        |-> processor_status_word[31:28] == alu_result[31:28])
        else $error("load missed bits 31:28");
    chk_load_low: assert property (flags_update && $past(issue_status_load, 2) && !$past(issue_is_mask, 2)
        |-> processor_status_word[1:0] == alu_result[1:0])
        else $error("load missed bits 1:0");
    chk_mask_load: assert property (flags_update && $past(issue_status_load, 2) && $past(issue_is_mask, 2)
        && !$past(reg_wr) |-> processor_status_word[27:0] == $past(processor_status_word[27:0]))
        else $error("mask load touched low bits");
    chk_skip_quiet: assert property (test_skipped && !$past(reg_wr)
        |-> $stable(processor_status_word) && $stable(alu_result))
        else $error("skipped test changed state");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data not zero when idle");
endmodule

bind ltf_unit ltf_monitor ltf_monitor_inst (.*);

// file: tb/tb.sv
// Random self-checking bench for the logical test flag unit.
// Assumes answers two edges after issue, read data one cycle after.
`timescale 1ns/100ps
module tb;
    logic        ref_clk, rst, issue_valid, issue_is_mask, issue_status_load, op2_is_imm;
    logic        shift_by_register, wb_en, reg_wr, reg_rd, flags_update, test_skipped;
    logic [3:0]  issue_cond, first_operand_register, imm_rotate, shifted_operand_register;
    logic [3:0]  shift_amount_register, wb_idx;
    logic [7:0]  imm_value, reg_addr;
    logic [2:0]  shift_kind;
    logic [4:0]  shift_const;
    logic [31:0] wb_data, reg_wdata, reg_rdata, processor_status_word, alu_result;
    logic [31:0] sh [16];
    logic [31:0] st, ealu, cnt;
    int          num_errors, num_checks, seed;

    ltf_unit ltf_unit_inst (.*);

    // ==========================================================
    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ==========================================================
    // Expectation functions
    function automatic logic cond_ok(logic [3:0] c, logic [3:0] f);
        logic r;
        case (c[3:1])
            3'd0: r = f[2];
            3'd1: r = f[1];
            3'd2: r = f[3];
            3'd3: r = f[0];
            3'd4: r = f[1] & ~f[2];
            3'd5: r = (f[3] == f[0]);
            3'd6: r = ~f[2] & (f[3] == f[0]);
            default: r = 1'b1;
        endcase
        return c[0] ? ~r : r;
    endfunction

    // Carry and shifted value
    function automatic logic [32:0] shf(logic [31:0] v, logic [2:0] k, int n, logic c);
        logic [63:0] w;
        if (k == 3'd5) return {v[0], c, v[31:1]};
        if (n == 0) return {c, v};
        case (k)
            3'd0, 3'd1: begin
                w = {32'h0000_0000, v} << n;
                return {w[32], w[31:0]};
            end
            3'd2: begin
                w = {v, 32'h0000_0000} >> n;
                return {w[31], w[63:32]};
            end
            3'd3: begin
                if (n >= 32) return {v[31], {32{v[31]}}};
                w = $signed({v, 32'h0000_0000}) >>> n;
                return {w[31], w[63:32]};
            end
            default: begin
                if (n % 32 == 0) return {v[31], v};
                w = {v, v} >> (n % 32);
                return {w[31], w[31:0]};
            end
        endcase
    endfunction

    // ==========================================================
    // Compare and report
    task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ==========================================================
    // Register port and store
    task automatic wreg(logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rreg(logic [7:0] a, logic [31:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e, "register read");
    endtask

    task automatic wstore(logic [3:0] i, logic [31:0] d);
        @(posedge ref_clk);
        wb_en <= 1'b1; wb_idx <= i; wb_data <= d;
        sh[i] = d;
        @(posedge ref_clk);
        wb_en <= 1'b0;
    endtask

    // ==========================================================
    // One random test and its expected outcome
    task automatic do_test(int i);
        logic [63:0] w;
        logic [32:0] s;
        logic [31:0] res;
        logic [3:0]  c, rn, rt, rm, rs;
        logic [7:0]  im;
        logic [4:0]  sc;
        logic [2:0]  k;
        logic        m, ld, br, ii, pass;
        m = $random(seed); c = $random(seed); ld = ($random(seed) & 3) == 0;
        rn = $random(seed); rt = $random(seed); rm = $random(seed); rs = $random(seed);
        im = $random(seed); sc = $random(seed); k = 3'(i % 6); ii = (i % 5) == 0; br = i[0];
        if (k == 3'd5) begin
            sc = 5'h01; br = 1'b0; ii = 1'b0;
        end
        w = {24'h00_0000, im, 24'h00_0000, im} >> (2 * rt);
        if (ii) s = {(rt == 4'h0) ? st[29] : w[31], w[31:0]};
        else s = shf(sh[rm], k, br ? int'(sh[rs][7:0]) : int'(sc), st[29]);
        res = m ? (sh[rn] & s[31:0]) : (sh[rn] ^ s[31:0]);
        pass = cond_ok(c, st[31:28]);
        @(posedge ref_clk);
        issue_valid <= 1'b1; issue_is_mask <= m; issue_cond <= c; issue_status_load <= ld;
        first_operand_register <= rn; op2_is_imm <= ii; imm_value <= im; imm_rotate <= rt;
        shifted_operand_register <= rm; shift_amount_register <= rs; shift_by_register <= br;
        shift_kind <= k; shift_const <= sc;
        @(posedge ref_clk);
        issue_valid <= 1'b0;
        if (pass) begin
            ealu = res;
            cnt++;
            if (ld) begin
                st[31:28] = res[31:28];
                if (!m) st[1:0] = res[1:0];
            end else begin
                st[31:29] = {res[31], res == 32'h0000_0000, m ? s[32] : 1'b0};
            end
        end
        @(posedge ref_clk);
        #1;
        chk(32'(flags_update), 32'(pass), "update pulse");
        chk(32'(test_skipped), 32'(!pass), "skip pulse");
        chk(processor_status_word, st, "status word");
        chk(alu_result, ealu, "logic result");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        seed = 69; num_errors = 0; num_checks = 0; cnt = 32'h0000_0000; ealu = 32'h0000_0000;
        rst = 1'b1; issue_valid = 1'b0; issue_is_mask = 1'b0; issue_cond = 4'h0; issue_status_load = 1'b0;
        first_operand_register = 4'h0; op2_is_imm = 1'b0; imm_value = 8'h00; imm_rotate = 4'h0;
        shifted_operand_register = 4'h0; shift_amount_register = 4'h0; shift_by_register = 1'b0;
        shift_kind = 3'h0; shift_const = 5'h00; wb_en = 1'b0; wb_idx = 4'h0; wb_data = 32'h0000_0000;
        reg_addr = 8'h00; reg_wdata = 32'h0000_0000; reg_wr = 1'b0; reg_rd = 1'b0;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        st = ltf_pkg::STATUS_RESET;
        #1 chk(processor_status_word, st, "status after reset");
        for (int i = 0; i < 16; i++)
            wstore(4'(i), (i == 0) ? 32'h0000_0020 : (i == 1) ? 32'h0000_0001 :
                   (i < 8) ? {$random(seed)} % 40 : $random(seed));
        rreg(ltf_pkg::COUNT_ADDR, cnt);
        rreg(8'h08, 32'h0000_0000);
        cnt = 32'h0000_0005;
        wreg(ltf_pkg::COUNT_ADDR, cnt);
        rreg(ltf_pkg::COUNT_ADDR, cnt);
        for (int i = 0; i < 400; i++) begin
            if (i % 8 == 0) begin
                st = $random(seed);
                wreg(ltf_pkg::STATUS_ADDR, st);
            end
            do_test(i);
            wstore(4'(2 + {$random(seed)} % 14), i[1] ? {$random(seed)} % 40 : $random(seed));
            if (i % 50 == 49) rreg(ltf_pkg::COUNT_ADDR, cnt);
            if (i % 50 == 25) rreg(ltf_pkg::STATUS_ADDR, st);
        end
        final_report();
    end

    // ==========================================================
    // Watchdog
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        final_report();
    end
endmodule
